// ==== core/bvc_blank_timer.sv ====
`include "bvc_params.svh"

module bvc_blank_timer #(
  parameter int unsigned BLANK_CYCLES = `BVC_BLANK_CYCLES
)
(
  // Clock, reset and enable
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // Control
  input  wire logic start_i,
  output logic      active_o
);

  logic [`BVC_TMR_W-1:0] count_r;

  // Restart on every write, so back-to-back writes extend the window
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      count_r <= `BVC_TMR_ZERO;
    end
    else if (ce_i)
    begin
      if (start_i)
      begin
        count_r <= BLANK_CYCLES[`BVC_TMR_W-1:0];
      end
      else if (count_r != `BVC_TMR_ZERO)
      begin
        count_r <= count_r - `BVC_TMR_ONE;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      active_o <= 1'b0;
    end
    else if (ce_i)
    begin
      active_o <= start_i || (count_r > `BVC_TMR_ONE);
    end
  end

endmodule

// ==== core/bvc_params.svh ====
// How it works
// - Locked writes leave both converter registers unchanged
// - Second rail write blanks its monitors 5 ms
// - Third rail write blanks its monitors 5 ms
// - Second code applies only on a go pulse
// - Bit 7 is pulse-skip enable, resets one
// - Bit 6 reads zero, writes ignored
// - Second register at 0x17, resets 0x99
// - Second code: 0.850 V, 10/25 mV steps
// - Third register at 0x18, nominal reset 0x8C
// - Strap input picks third code power-up value
// - Third code: 0.900 V, 25/50 mV steps
`ifndef BVC_PARAMS_SVH
`define BVC_PARAMS_SVH

`define BVC_ADDR_SECOND      8'h17
`define BVC_ADDR_THIRD       8'h18
`define BVC_RESET_SECOND     8'h99
`define BVC_RESET_THIRD      8'h8C
`define BVC_BIT_PSK          7
`define BVC_BIT_RSVD         6
`define BVC_CODE_MSB         5
`define BVC_READ_ZERO        8'h00

`define BVC_BLANK_TIME_US    5000
`define BVC_CLK_MHZ          50
`define BVC_BLANK_CYCLES     (`BVC_BLANK_TIME_US * `BVC_CLK_MHZ)
`define BVC_TMR_W            18
`define BVC_TMR_ONE          18'h00001
`define BVC_TMR_ZERO         18'h00000

// Strapped third-rail codes; index 0 is the nominal default
`define BVC_STRAP_CODE0      6'h0C
`define BVC_STRAP_CODE1      6'h08
`define BVC_STRAP_CODE2      6'h10
`define BVC_STRAP_CODE3      6'h1A

// Voltage maps in millivolts
`define BVC_SEC_BASE_MV      12'd850
`define BVC_SEC_STEP1_MV     12'd10
`define BVC_SEC_KNEE         6'h32
`define BVC_SEC_STEP2_MV     12'd25
`define BVC_THR_BASE_MV      12'd900
`define BVC_THR_STEP1_MV     12'd25
`define BVC_THR_KNEE         6'h1A
`define BVC_THR_STEP2_MV     12'd50

`endif

// ==== core/bvc_pkg.sv ====
package bvc_pkg;

  typedef logic [5:0]  bvc_code_t;
  typedef logic [11:0] bvc_mv_t;

  typedef enum logic [0:0]
  {
    BVC_ST_STRAP = 1'b0,
    BVC_ST_RUN   = 1'b1
  } bvc_state_e;

endpackage

// ==== core/bvc_regs.sv ====
`include "bvc_params.svh"

module bvc_regs #(
  parameter int unsigned BLANK_CYCLES = `BVC_BLANK_CYCLES
)
(
  // Clock, reset, enable
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        CE_I,
  // Register port
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic [7:0]  REG_WDATA_I,
  input  wire logic        REG_UNLOCK_I,
  output logic      [7:0]  REG_RDATA_O,
  // Apply controls from the go register
  input  wire logic        APPLY_VOLTAGE_GO_I,
  input  wire logic        APPLY_VOLTAGE_NO_DISCHARGE_BIT_I,
  // Strap
  input  wire logic [1:0]  STRAP_RESISTOR_SELECT_I,
  // Raw supervisor comparators
  input  wire logic        SECOND_OV_RAW_I,
  input  wire logic        SECOND_UV_RAW_I,
  input  wire logic        THIRD_OV_RAW_I,
  input  wire logic        THIRD_UV_RAW_I,
  // Converter controls
  output logic      [5:0]  SECOND_BUCK_VOLTAGE_CODE_O,
  output logic      [5:0]  THIRD_BUCK_VOLTAGE_CODE_O,
  output logic             SECOND_PULSE_SKIP_ENABLE_O,
  output logic             THIRD_PULSE_SKIP_ENABLE_O,
  output logic      [11:0] SECOND_BUCK_MV_O,
  output logic      [11:0] THIRD_BUCK_MV_O,
  // Supervisor results
  output logic             SECOND_BLANK_O,
  output logic             THIRD_BLANK_O,
  output logic             SECOND_OV_FAULT_O,
  output logic             SECOND_UV_FAULT_O,
  output logic             THIRD_OV_FAULT_O,
  output logic             THIRD_UV_FAULT_O
);

  // Piecewise-linear code to millivolt conversion
  function automatic bvc_pkg::bvc_mv_t code_to_mv(
    input bvc_pkg::bvc_code_t code,
    input bvc_pkg::bvc_mv_t   base,
    input bvc_pkg::bvc_mv_t   step1,
    input bvc_pkg::bvc_code_t knee,
    input bvc_pkg::bvc_mv_t   step2
  );
    bvc_pkg::bvc_mv_t lo;
    bvc_pkg::bvc_mv_t hi;
    if (code <= knee)
    begin
      lo = 12'(code) * step1;
      hi = 12'h000;
    end
    else
    begin
      lo = 12'(knee) * step1;
      hi = 12'(code - knee) * step2;
    end
    return 12'(base + lo + hi);
  endfunction

  // Strapped power-up code lookup
  function automatic bvc_pkg::bvc_code_t strap_code(
    input logic [1:0] sel
  );
    bvc_pkg::bvc_code_t c;
    c = `BVC_STRAP_CODE0;
    case (sel)
      2'h1:    c = `BVC_STRAP_CODE1;
      2'h2:    c = `BVC_STRAP_CODE2;
      2'h3:    c = `BVC_STRAP_CODE3;
      default: c = `BVC_STRAP_CODE0;
    endcase
    return c;
  endfunction

  bvc_pkg::bvc_state_e state_r;
  bvc_pkg::bvc_state_e state_nxt;
  bvc_pkg::bvc_code_t  second_code_r;
  bvc_pkg::bvc_code_t  third_code_r;
  logic                second_psk_r;
  logic                third_psk_r;
  logic                wr_second;
  logic                wr_third;
  logic                wr_ok;
  logic                apply_second;
  logic                second_blank;
  logic                third_blank;

  // Named copies so reset fields can be sliced; a literal cannot be
  localparam logic [7:0] RST_SECOND = `BVC_RESET_SECOND;
  localparam logic [7:0] RST_THIRD  = `BVC_RESET_THIRD;

  // Strap is caught at the first enabled edge after release, never in reset
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      bvc_pkg::BVC_ST_STRAP: state_nxt = bvc_pkg::BVC_ST_RUN;
      bvc_pkg::BVC_ST_RUN:   state_nxt = bvc_pkg::BVC_ST_RUN;
      default:               state_nxt = bvc_pkg::BVC_ST_STRAP;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state_r <= bvc_pkg::BVC_ST_STRAP;
    end
    else if (CE_I)
    begin
      state_r <= state_nxt;
    end
  end

  // Writes count only once running and unlocked
  assign wr_ok = REG_WR_I && REG_UNLOCK_I && (state_r == bvc_pkg::BVC_ST_RUN);

  always_comb
  begin
    wr_second = 1'b0;
    wr_third  = 1'b0;
    if (REG_ADDR_I == `BVC_ADDR_SECOND)
    begin
      wr_second = wr_ok;
    end
    else if (REG_ADDR_I == `BVC_ADDR_THIRD)
    begin
      wr_third = wr_ok;
    end
  end

  assign apply_second = APPLY_VOLTAGE_GO_I || APPLY_VOLTAGE_NO_DISCHARGE_BIT_I;

  // Second converter register
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      second_psk_r  <= RST_SECOND[`BVC_BIT_PSK];
      second_code_r <= RST_SECOND[`BVC_CODE_MSB:0];
    end
    else if (CE_I && wr_second)
    begin
      second_psk_r  <= REG_WDATA_I[`BVC_BIT_PSK];
      second_code_r <= REG_WDATA_I[`BVC_CODE_MSB:0];
    end
  end

  // Third converter register
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      third_psk_r  <= RST_THIRD[`BVC_BIT_PSK];
      third_code_r <= RST_THIRD[`BVC_CODE_MSB:0];
    end
    else if (CE_I)
    begin
      if (state_r == bvc_pkg::BVC_ST_STRAP)
      begin
        third_code_r <= strap_code(STRAP_RESISTOR_SELECT_I);
      end
      else if (wr_third)
      begin
        third_psk_r  <= REG_WDATA_I[`BVC_BIT_PSK];
        third_code_r <= REG_WDATA_I[`BVC_CODE_MSB:0];
      end
    end
  end

  // Second rail holds the old code until a go pulse
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      SECOND_BUCK_VOLTAGE_CODE_O <= RST_SECOND[`BVC_CODE_MSB:0];
      SECOND_BUCK_MV_O           <= code_to_mv(
        RST_SECOND[`BVC_CODE_MSB:0], `BVC_SEC_BASE_MV,
        `BVC_SEC_STEP1_MV, `BVC_SEC_KNEE, `BVC_SEC_STEP2_MV);
    end
    else if (CE_I && apply_second)
    begin
      SECOND_BUCK_VOLTAGE_CODE_O <= second_code_r;
      SECOND_BUCK_MV_O           <= code_to_mv(second_code_r,
        `BVC_SEC_BASE_MV, `BVC_SEC_STEP1_MV, `BVC_SEC_KNEE,
        `BVC_SEC_STEP2_MV);
    end
  end

  // Third rail follows its register directly
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      THIRD_BUCK_VOLTAGE_CODE_O <= RST_THIRD[`BVC_CODE_MSB:0];
      THIRD_BUCK_MV_O           <= code_to_mv(
        RST_THIRD[`BVC_CODE_MSB:0], `BVC_THR_BASE_MV,
        `BVC_THR_STEP1_MV, `BVC_THR_KNEE, `BVC_THR_STEP2_MV);
    end
    else if (CE_I)
    begin
      THIRD_BUCK_VOLTAGE_CODE_O <= third_code_r;
      THIRD_BUCK_MV_O           <= code_to_mv(third_code_r,
        `BVC_THR_BASE_MV, `BVC_THR_STEP1_MV, `BVC_THR_KNEE,
        `BVC_THR_STEP2_MV);
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      SECOND_PULSE_SKIP_ENABLE_O <= RST_SECOND[`BVC_BIT_PSK];
      THIRD_PULSE_SKIP_ENABLE_O  <= RST_THIRD[`BVC_BIT_PSK];
    end
    else if (CE_I)
    begin
      SECOND_PULSE_SKIP_ENABLE_O <= second_psk_r;
      THIRD_PULSE_SKIP_ENABLE_O  <= third_psk_r;
    end
  end

  // Registered read; unmapped addresses return zero
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      REG_RDATA_O <= `BVC_READ_ZERO;
    end
    else if (CE_I && REG_RD_I)
    begin
      if (REG_ADDR_I == `BVC_ADDR_SECOND)
      begin
        REG_RDATA_O <= {second_psk_r, 1'b0, second_code_r};
      end
      else if (REG_ADDR_I == `BVC_ADDR_THIRD)
      begin
        REG_RDATA_O <= {third_psk_r, 1'b0, third_code_r};
      end
      else
      begin
        REG_RDATA_O <= `BVC_READ_ZERO;
      end
    end
  end

  bvc_blank_timer #(
    .BLANK_CYCLES (BLANK_CYCLES)
  ) u_second_blank (
    .clk_i    (CORE_CLK_I),
    .rst_n_i  (RST_N_I),
    .ce_i     (CE_I),
    .start_i  (wr_second),
    .active_o (second_blank)
  );

  bvc_blank_timer #(
    .BLANK_CYCLES (BLANK_CYCLES)
  ) u_third_blank (
    .clk_i    (CORE_CLK_I),
    .rst_n_i  (RST_N_I),
    .ce_i     (CE_I),
    .start_i  (wr_third),
    .active_o (third_blank)
  );

  // Gate comparators for the blanking window after each rail write; a second-rail go does not start blanking
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      SECOND_BLANK_O    <= 1'b0;
      THIRD_BLANK_O     <= 1'b0;
      SECOND_OV_FAULT_O <= 1'b0;
      SECOND_UV_FAULT_O <= 1'b0;
      THIRD_OV_FAULT_O  <= 1'b0;
      THIRD_UV_FAULT_O  <= 1'b0;
    end
    else if (CE_I)
    begin
      SECOND_BLANK_O    <= second_blank;
      THIRD_BLANK_O     <= third_blank;
      SECOND_OV_FAULT_O <= SECOND_OV_RAW_I && !second_blank;
      SECOND_UV_FAULT_O <= SECOND_UV_RAW_I && !second_blank;
      THIRD_OV_FAULT_O  <= THIRD_OV_RAW_I && !third_blank;
      THIRD_UV_FAULT_O  <= THIRD_UV_RAW_I && !third_blank;
    end
  end

endmodule

// ==== tb/buck_voltage_ctrl_regs_test.sv ====
module buck_voltage_ctrl_regs_test;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int unsigned BC = 20;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr, rd, unl, go, nd;
  logic [7:0]  addr, wdata, rdata, q;
  logic [1:0]  strap = 2'h0;
  logic        ov2 = 1'b0;
  logic        ov3 = 1'b0;
  logic [5:0]  code2, code3;
  logic        psk2, psk3, bl2, bl3, f2o, f3o;
  logic [11:0] mv2, mv3;
  logic [5:0]  c3 [3] = '{6'h00, 6'h1A, 6'h3F};
  logic [11:0] v3 [3] = '{12'h384, 12'h60E, 12'hD48};
  int          num_errors = 0;
  int          cmp_count = 0;
  int          n;

  always #10 clk = ~clk;

  bvc_regs #(.BLANK_CYCLES(BC)) dut (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_UNLOCK_I(unl), .REG_RDATA_O(rdata),
    .APPLY_VOLTAGE_GO_I(go), .APPLY_VOLTAGE_NO_DISCHARGE_BIT_I(nd),
    .STRAP_RESISTOR_SELECT_I(strap),
    .SECOND_OV_RAW_I(ov2), .SECOND_UV_RAW_I(1'b0),
    .THIRD_OV_RAW_I(ov3), .THIRD_UV_RAW_I(1'b0),
    .SECOND_BUCK_VOLTAGE_CODE_O(code2),
    .THIRD_BUCK_VOLTAGE_CODE_O(code3),
    .SECOND_PULSE_SKIP_ENABLE_O(psk2),
    .THIRD_PULSE_SKIP_ENABLE_O(psk3),
    .SECOND_BUCK_MV_O(mv2), .THIRD_BUCK_MV_O(mv3),
    .SECOND_BLANK_O(bl2), .THIRD_BLANK_O(bl3),
    .SECOND_OV_FAULT_O(f2o), .SECOND_UV_FAULT_O(),
    .THIRD_OV_FAULT_O(f3o), .THIRD_UV_FAULT_O()
  );

  bvc_host u_host (
    .clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr),
    .wdata_o(wdata), .unlock_o(unl), .rdata_i(rdata),
    .go_o(go), .nodis_o(nd)
  );

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] s);
    rst_n = 1'b0;
    strap = s;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask

  initial
  begin
    do_reset(2'h0);
    u_host.rd(8'h17, q);
    chk(q, 8'h99);
    u_host.rd(8'h18, q);
    chk(q, 8'h8C);
    u_host.rd(8'h42, q);
    chk(q, 8'h00);
    chk(mv2, 12'h44C);
    chk(mv3, 12'h4B0);
    ov2 = 1'b1;
    u_host.wr(8'h17, 8'h00, 1'b0);
    chk(bl2, 1'b0);
    chk(f2o, 1'b1);
    u_host.rd(8'h17, q);
    chk(q, 8'h99);
    u_host.wr(8'h17, 8'h7F, 1'b1);
    // Blank flag and fault gate lag the write edge by one cycle
    @(negedge clk);
    chk(f2o, 1'b0);
    n = 0;
    while (bl2 === 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    chk(12'(n), 12'(BC));
    if (n == 40)
      end_of_test();
    u_host.rd(8'h17, q);
    chk(q, 8'h3F);
    chk(f2o, 1'b1);
    chk(psk2, 1'b0);
    chk(code2, 6'h19);
    u_host.go(1'b0);
    chk(mv2, 12'h68B);
    u_host.wr(8'h17, 8'hB2, 1'b1);
    u_host.go(1'b1);
    chk(code2, 6'h32);
    chk(mv2, 12'h546);
    for (int i = 0; i < 3; i++)
    begin
      u_host.wr(8'h18, {i[0], 1'b1, c3[i]}, 1'b1);
      ov3 = 1'b1;
      @(negedge clk);
      chk(bl3, 1'b1);
      chk(f3o, 1'b0);
      chk(code3, c3[i]);
      chk(mv3, v3[i]);
      u_host.rd(8'h18, q);
      chk(q, {i[0], 1'b0, c3[i]});
      chk(psk3, i[0]);
    end
    // Reset lands mid-blank on purpose
    do_reset(2'h3);
    u_host.rd(8'h18, q);
    chk(q, 8'h9A);
    end_of_test();
  end
endmodule

// ==== tb/bvc_host.sv ====
module bvc_host
(
  // Clock
  input  wire logic       clk_i,
  // Register port
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            unlock_o,
  input  wire logic [7:0] rdata_i,
  // Apply controls
  output logic            go_o,
  output logic            nodis_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    {wr_o, rd_o, unlock_o, go_o, nodis_o} = 5'h00;
    addr_o  = 8'h00;
    wdata_o = 8'h00;
  end

  // Released address and data lines get the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic u);
    @(negedge clk_i);
    wr_o     = 1'b1;
    addr_o   = a;
    wdata_o  = d;
    unlock_o = u;
    @(negedge clk_i);
    wr_o     = 1'b0;
    unlock_o = 1'b0;
    addr_o   = ~a;
    wdata_o  = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge clk_i);
    rd_o   = 1'b1;
    addr_o = a;
    @(negedge clk_i);
    rd_o   = 1'b0;
    addr_o = ~a;
    q      = rdata_i;
  endtask

  task automatic go(input logic nd);
    @(negedge clk_i);
    go_o    = ~nd;
    nodis_o = nd;
    @(negedge clk_i);
    go_o    = 1'b0;
    nodis_o = 1'b0;
  endtask
endmodule

// ==== tb/bvc_regs_asserts.sv ====
`include "bvc_params.svh"

module bvc_regs_asserts #(
  parameter int unsigned BLANK_CYCLES = `BVC_BLANK_CYCLES
)
(
  input wire logic       CORE_CLK_I,
  input wire logic       RST_N_I,
  input wire logic       CE_I,
  input wire logic       REG_WR_I,
  input wire logic       REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic       REG_UNLOCK_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic       APPLY_VOLTAGE_GO_I,
  input wire logic       APPLY_VOLTAGE_NO_DISCHARGE_BIT_I,
  input wire logic [5:0] SECOND_BUCK_VOLTAGE_CODE_O,
  input wire logic       SECOND_PULSE_SKIP_ENABLE_O,
  input wire logic       SECOND_BLANK_O,
  input wire logic       THIRD_BLANK_O,
  input wire logic       SECOND_OV_FAULT_O
);
  logic        up_r;
  logic [5:0]  sh_r;
  int unsigned cnt_r;
  logic        acc2;
  logic        acc3;

  // First edge after reset drops writes
  assign acc2 = up_r && CE_I && REG_WR_I && REG_UNLOCK_I
                && REG_ADDR_I == 8'h17;
  assign acc3 = up_r && CE_I && REG_WR_I && REG_UNLOCK_I
                && REG_ADDR_I == 8'h18;

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      up_r  <= 1'b0;
      sh_r  <= 6'h19;
      cnt_r <= 0;
    end
    else if (CE_I)
    begin
      up_r  <= 1'b1;
      sh_r  <= acc2 ? REG_WDATA_I[5:0] : sh_r;
      cnt_r <= (acc2 || !SECOND_BLANK_O) ? 0 : cnt_r + 1;
    end
  end

  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  property p_locked;
    CE_I && REG_WR_I && !REG_UNLOCK_I && !SECOND_BLANK_O && !$past(acc2)
      |=> !SECOND_BLANK_O;
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked write started blanking");

  property p_blank2;
    acc2 |-> ##2 SECOND_BLANK_O[*8];
  endproperty
  a_blank2: assert property (p_blank2)
    else $error("second rail not blanked after write");

  property p_blank_len;
    up_r && $fell(SECOND_BLANK_O) |-> cnt_r == BLANK_CYCLES;
  endproperty
  a_blank_len: assert property (p_blank_len)
    else $error("second blanking length wrong");

  property p_blank3;
    acc3 |-> ##2 THIRD_BLANK_O[*8];
  endproperty
  a_blank3: assert property (p_blank3)
    else $error("third rail not blanked after write");

  property p_go;
    CE_I && (APPLY_VOLTAGE_GO_I || APPLY_VOLTAGE_NO_DISCHARGE_BIT_I)
      |=> SECOND_BUCK_VOLTAGE_CODE_O == $past(sh_r);
  endproperty
  a_go: assert property (p_go)
    else $error("go did not apply stored code");

  property p_psk;
    acc2 ##1 !acc2[*2]
      |=> SECOND_PULSE_SKIP_ENABLE_O == $past(REG_WDATA_I[7], 3);
  endproperty
  a_psk: assert property (p_psk)
    else $error("pulse-skip output does not follow write");

  property p_rd6;
    CE_I && REG_RD_I |=> !REG_RDATA_O[6];
  endproperty
  a_rd6: assert property (p_rd6)
    else $error("reserved bit read as one");

  property p_fault;
    SECOND_BLANK_O |-> !SECOND_OV_FAULT_O;
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault flag raised while blanking");
endmodule

bind bvc_regs bvc_regs_asserts #(.BLANK_CYCLES(BLANK_CYCLES)) u_chk (.*);
